// >>> hdl/decd_detector.v
// Purpose: error detection and status code of a disk controller
// Assumes: inputs synchronous to clk; sequencer pulses are one cycle
// Notes: code held until sense read or next command start
// Behaviour
// - Recalibrate: no track zero after cylinders+200 steps
// - Drive-ready test during seek reports 08
// - Uninitialised drive access rejected with 0a
// - Tape access before drive 0 init: 0a
// - Write to protected drive blocked, 0b
// - Marks seen, sector missing, ID ECC: 10
// - Error span beyond burst length: 11
// - No address mark within window: 12
// - Sector not found in two revolutions: 14
// - ID cylinder or head mismatch: 15
// - Corrected read error still reports 18
// - Code given by sense and completion byte
// - Clean completion returns 00
// - Over 20 errors aborts the command
`timescale 1ns/1ps
`include "decd_defines.vh"
module decd_detector #(
	parameter DRV_W = 2,
	parameter CYL_W = 16,
	parameter BURST_W = 8,
	parameter MARK_WIN = `DECD_MARK_WIN_CYC
)
(
	input wire clk,
	input wire rst_b,
	input wire cmd_start,
	input wire [DRV_W-1:0] cmd_drive,
	input wire cmd_tape,
	input wire cmd_write,
	input wire cmd_recal,
	input wire cmd_seek,
	input wire cmd_test_ready,
	input wire cmd_xfer,
	input wire cmd_init,
	input wire [BURST_W-1:0] init_burst,
	input wire [CYL_W-1:0] init_cyls,
	input wire cmd_done,
	input wire sense_rd,
	input wire step_pulse,
	input wire track0,
	input wire seek_done,
	input wire write_prot,
	input wire index_pulse,
	input wire addr_mark,
	input wire id_valid,
	input wire id_ecc_err,
	input wire id_match,
	input wire [CYL_W-1:0] id_cyl,
	input wire [7:0] id_head,
	input wire [CYL_W-1:0] tgt_cyl,
	input wire [7:0] tgt_head,
	input wire data_valid,
	input wire data_err,
	input wire [BURST_W-1:0] err_span,
	output reg [7:0] status_q,
	output reg [7:0] msg_q,
	output reg msg_valid_q,
	output reg reject_q,
	output reg abort_q
);
	localparam S_IDLE = 3'b001;
	localparam S_RUN = 3'b010;
	localparam S_END = 3'b100;

	reg [2:0] state_q;
	reg [DRV_W-1:0] drv_q;
	reg recal_q;
	reg xfer_q;
	reg seek_busy_q;
	reg [CYL_W:0] steps_q;
	reg [CYL_W-1:0] cyls_q;
	reg [31:0] win_q;
	reg [1:0] revs_q;
	reg marks_q;
	reg id_bad_q;
	reg [4:0] errs_q;
	reg [7:0] code_d;
	reg hit_d;
	wire [BURST_W:0] init_word;
	wire d0_init;
	wire [BURST_W:0] rd_word;

	// Code priority: first error in a cycle wins; a cycle adds one count however many hit
	function [7:0] pick;
		input [7:0] cur;
		input [7:0] nxt;
		begin
			pick = (cur == `DECD_ERR_NONE) ? nxt : cur;
		end
	endfunction

	// ==========================================
	// Per-drive init memory; burst length read for the current drive
	assign init_word = {1'b1, init_burst};
	decd_init_mem #(.AW(DRV_W), .DW(BURST_W+1)) u_mem (
		.clk(clk),
		.rst_b(rst_b),
		.wr_en(cmd_init),
		.wr_addr(cmd_drive),
		.wr_data(init_word),
		.rd_addr(state_q == S_IDLE ? cmd_drive : drv_q),
		.rd_data_q(rd_word)
	);

	// Drive 0 flag kept apart so tape checks need no second read port
	reg d0_init_q;
	assign d0_init = d0_init_q;

	// ==========================================
	// Error conditions of the running command
	always @*
	begin
		code_d = `DECD_ERR_NONE;
		// Checked once the last allowed step is out, not on an extra step
		if (recal_q && !track0
			&& steps_q >= {1'b0, cyls_q} + `DECD_RECAL_EXTRA)
			code_d = pick(code_d, `DECD_ERR_TRK0);
		if (xfer_q && marks_q && id_bad_q && index_pulse
			&& revs_q == `DECD_MAX_REVS - 2'h1)
			code_d = pick(code_d, `DECD_ERR_IDECC);
		if (xfer_q && index_pulse && revs_q == `DECD_MAX_REVS - 2'h1)
			code_d = pick(code_d, `DECD_ERR_NOSECT);
		if (xfer_q && win_q >= MARK_WIN)
			code_d = pick(code_d, `DECD_ERR_NOMARK);
		if (xfer_q && id_valid && !id_ecc_err
			&& (id_cyl != tgt_cyl || id_head != tgt_head))
			code_d = pick(code_d, `DECD_ERR_SEEK);
		if (xfer_q && data_valid && data_err)
			code_d = pick(code_d, err_span > rd_word[BURST_W-1:0]
				? `DECD_ERR_UNCORR : `DECD_ERR_CORR);
		hit_d = (code_d != `DECD_ERR_NONE);
	end

	// ==========================================
	// Command sequencing, counters and status byte
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= S_IDLE;
			drv_q <= {DRV_W{1'b0}};
			recal_q <= 1'b0;
			xfer_q <= 1'b0;
			seek_busy_q <= 1'b0;
			steps_q <= {(CYL_W+1){1'b0}};
			cyls_q <= {CYL_W{1'b0}};
			win_q <= 32'h0;
			revs_q <= 2'h0;
			marks_q <= 1'b0;
			id_bad_q <= 1'b0;
			errs_q <= 5'h0;
			d0_init_q <= 1'b0;
			status_q <= `DECD_ERR_NONE;
			msg_q <= `DECD_ERR_NONE;
			msg_valid_q <= 1'b0;
			reject_q <= 1'b0;
			abort_q <= 1'b0;
		end
		else
		begin
			msg_valid_q <= 1'b0;
			reject_q <= 1'b0;
			abort_q <= 1'b0;
			if (cmd_init)
			begin
				cyls_q <= init_cyls;
				if (cmd_drive == {DRV_W{1'b0}})
					d0_init_q <= 1'b1;
			end
			// Seek busy spans commands; cleared by the drive
			if (seek_done)
				seek_busy_q <= 1'b0;
			if (sense_rd)
				status_q <= `DECD_ERR_NONE;
			case (state_q)
			S_IDLE:
			begin
				if (cmd_start)
				begin
					status_q <= `DECD_ERR_NONE;
					drv_q <= cmd_drive;
					errs_q <= 5'h0;
					steps_q <= {(CYL_W+1){1'b0}};
					win_q <= 32'h0;
					revs_q <= 2'h0;
					marks_q <= 1'b0;
					id_bad_q <= 1'b0;
					state_q <= S_RUN;
					recal_q <= cmd_recal;
					xfer_q <= cmd_xfer;
					if (cmd_seek)
						seek_busy_q <= 1'b1;
				end
			end
			S_RUN:
			begin
				// Checks need the memory word, one cycle after start
				if (cmd_tape && !d0_init)
				begin
					status_q <= `DECD_ERR_NOINIT;
					reject_q <= 1'b1;
					state_q <= S_END;
				end
				else if (!cmd_tape && !cmd_init && !rd_word[BURST_W])
				begin
					status_q <= `DECD_ERR_NOINIT;
					reject_q <= 1'b1;
					state_q <= S_END;
				end
				else if (cmd_write && write_prot)
				begin
					status_q <= `DECD_ERR_WPROT;
					reject_q <= 1'b1;
					state_q <= S_END;
				end
				else if (cmd_test_ready && seek_busy_q && !seek_done)
				begin
					status_q <= `DECD_ERR_SEEKING;
					state_q <= S_END;
				end
				else if (errs_q == `DECD_MAX_ERRORS && hit_d)
				begin
					status_q <= `DECD_ERR_MAXERR;
					abort_q <= 1'b1;
					state_q <= S_END;
				end
				else if (cmd_done)
					state_q <= S_END;
				else
				begin
					if (hit_d)
					begin
						status_q <= code_d;
						errs_q <= errs_q + 5'h1;
					end
					if (recal_q && track0)
						recal_q <= 1'b0;
					else if (recal_q && step_pulse)
						steps_q <= steps_q + 1'b1;
					// ID error means the sector search failed too: stop
					if (code_d == `DECD_ERR_TRK0 || code_d == `DECD_ERR_NOSECT
						|| code_d == `DECD_ERR_IDECC)
					begin
						recal_q <= 1'b0;
						xfer_q <= 1'b0;
						state_q <= S_END;
					end
					// Window restarts after a miss so each miss counts once
					if (addr_mark || !xfer_q || win_q >= MARK_WIN)
						win_q <= 32'h0;
					else
						win_q <= win_q + 32'h1;
					if (addr_mark)
						marks_q <= 1'b1;
					if (id_valid && id_ecc_err)
						id_bad_q <= 1'b1;
					if (id_valid && id_match)
						revs_q <= 2'h0;
					else if (xfer_q && index_pulse)
						revs_q <= revs_q + 2'h1;
				end
			end
			S_END:
			begin
				recal_q <= 1'b0;
				xfer_q <= 1'b0;
				msg_q <= status_q;
				msg_valid_q <= 1'b1;
				state_q <= S_IDLE;
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end
endmodule // decd_detector

// >>> hdl/decd_defines.vh
// Purpose: constants for the disk error code detector
// Assumes: 200 MHz clock
// Notes: codes are one byte, hex
`ifndef DECD_DEFINES_VH
`define DECD_DEFINES_VH
`define DECD_ERR_NONE 8'h00
`define DECD_ERR_TRK0 8'h06
`define DECD_ERR_SEEKING 8'h08
`define DECD_ERR_NOINIT 8'h0a
`define DECD_ERR_WPROT 8'h0b
`define DECD_ERR_IDECC 8'h10
`define DECD_ERR_UNCORR 8'h11
`define DECD_ERR_NOMARK 8'h12
`define DECD_ERR_NOSECT 8'h14
`define DECD_ERR_SEEK 8'h15
`define DECD_ERR_CORR 8'h18
`define DECD_ERR_MAXERR 8'h33
`define DECD_RECAL_EXTRA 16'h00c8
`define DECD_MAX_ERRORS 5'h14
`define DECD_MAX_REVS 2'h2
`define DECD_MARK_WIN_NS 20000
`define DECD_CLK_NS 5
`define DECD_MARK_WIN_CYC ((`DECD_MARK_WIN_NS) / (`DECD_CLK_NS))
`define DECD_DRIVES 4
`endif

// >>> hdl/decd_init_mem.v
// Purpose: per-drive memory of initialised flag and burst length
// Assumes: single clock, registered read
// Notes: one word per drive, cleared at reset
`timescale 1ns/1ps
module decd_init_mem #(
	parameter AW = 2,
	parameter DW = 9
)
(
	input wire clk,
	input wire rst_b,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data_q
);
	reg [DW-1:0] mem_q [0:(1<<AW)-1];
	integer i;

	// ==========================================
	// Storage and registered read
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < (1<<AW); i = i + 1)
				mem_q[i] <= {DW{1'b0}};
			rd_data_q <= {DW{1'b0}};
		end
		else
		begin
			if (wr_en)
				mem_q[wr_addr] <= wr_data;
			rd_data_q <= mem_q[rd_addr];
		end
	end
endmodule // decd_init_mem

// >>> bench/decd_detector_props.sv
// Purpose: port checks of the error code detector
// Assumes: one clock, rst_b async active low
// Notes: bound into decd_detector below
`timescale 1ns/1ps
// ==========
// Checker
module decd_props (
	input wire clk,
	input wire rst_b,
	input wire cmd_done,
	input wire sense_rd,
	input wire cmd_start,
	input wire [7:0] status_q,
	input wire [7:0] msg_q,
	input wire msg_valid_q,
	input wire reject_q,
	input wire abort_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Completion byte lands two edges after done
	sequence done_s;
		cmd_done ##2 msg_valid_q;
	endsequence
	a_msg_after_done: assert property (cmd_done |-> done_s)
		else $error("no message after done");
	a_msg_is_status: assert property (msg_valid_q |-> msg_q == status_q)
		else $error("message differs from status");
	a_msg_stands: assert property ($changed(msg_q) |-> msg_valid_q)
		else $error("message byte moved");
	a_msg_one_pulse: assert property (msg_valid_q |=> !msg_valid_q)
		else $error("message valid too long");
	a_sense_clears: assert property (sense_rd && !cmd_start
		|=> status_q == 8'h00)
		else $error("sense left a code");
	a_reject_code: assert property (reject_q |-> ##[0:1]
		(status_q == 8'h0a || status_q == 8'h0b))
		else $error("reject without code");
	a_reject_msg: assert property (reject_q |-> ##[0:2] msg_valid_q)
		else $error("reject without message");
	a_abort_code: assert property (abort_q |-> ##[0:1] status_q == 8'h33)
		else $error("abort without code");
	a_abort_msg: assert property (abort_q |=> msg_valid_q)
		else $error("abort without message");
endmodule // decd_props

bind decd_detector decd_props chk_u (.clk(clk), .rst_b(rst_b),
	.cmd_done(cmd_done), .sense_rd(sense_rd), .cmd_start(cmd_start),
	.status_q(status_q), .msg_q(msg_q), .msg_valid_q(msg_valid_q),
	.reject_q(reject_q), .abort_q(abort_q));

// >>> bench/decd_drive_model.sv
// Purpose: disk drive side stimulus
// Assumes: tasks entered 1 ns after a clock edge
// Notes: ID and data fields invert once their strobe drops
`timescale 1ns/1ps
// ==========
// Drive model
module decd_drive_model (
	input wire clk,
	output reg track0,
	output reg seek_done,
	output reg write_prot,
	output reg index_pulse,
	output reg addr_mark,
	output reg id_valid,
	output reg id_ecc_err,
	output reg id_match,
	output reg [15:0] id_cyl,
	output reg [7:0] id_head,
	output reg data_valid,
	output reg data_err,
	output reg [7:0] err_span
);
	// Idle drive: ready, unprotected, no track zero
	initial {track0, seek_done, write_prot, index_pulse, addr_mark, id_valid,
		id_ecc_err, id_match, id_cyl, id_head, data_valid, data_err,
		err_span} = {3'h2, 39'h0};
	task lvl(input w, input s);
		{write_prot, seek_done} = {w, s};
	endtask
	// Track zero level, held until changed
	task trk(input t);
		track0 = t;
	endtask
	task mark(input i);
		begin
			{addr_mark, index_pulse} = {~i, i};
			@(posedge clk) #1 {addr_mark, index_pulse} = 2'h0;
		end
	endtask
	// Stale fields are inverted so nothing reads them as valid
	task idf(input e, input m, input [15:0] c);
		begin
			{id_valid, id_ecc_err, id_match, id_cyl, id_head} = {1'h1, e, m, c, 8'h0};
			@(posedge clk) #1 {id_valid, id_ecc_err, id_match} = {1'h0, ~e, ~m};
			{id_cyl, id_head} = {~c, 8'hff};
		end
	endtask
	task dat(input e, input [7:0] s);
		begin
			{data_valid, data_err, err_span} = {1'h1, e, s};
			@(posedge clk) #1 {data_valid, data_err, err_span} = {1'h0, ~e, ~s};
		end
	endtask
endmodule // decd_drive_model

// >>> bench/decd_detector_bench.sv
// Purpose: self-checking bench of the error code detector
// Assumes: 200 MHz clock, short address mark window
// Notes: drive 0 holds burst 4 and 2 cylinders
`timescale 1ns/1ps
// ==========
// Bench
module decd_detector_bench;
	reg clk, rst_b, cmd_start, cmd_tape, cmd_write, cmd_recal, cmd_seek;
	reg cmd_test_ready, cmd_xfer, cmd_init, cmd_done, sense_rd, step_pulse;
	reg [1:0] cmd_drive;
	reg [7:0] init_burst, tgt_head;
	reg [15:0] init_cyls, tgt_cyl;
	wire track0, seek_done, write_prot, index_pulse, addr_mark, id_valid;
	wire id_ecc_err, id_match, data_valid, data_err, msg_valid_q, reject_q;
	wire abort_q;
	wire [15:0] id_cyl;
	wire [7:0] id_head, err_span, status_q, msg_q;
	integer n_errors = 0, samples_checked = 0, i;
	decd_detector #(.MARK_WIN(20)) dut_u (.clk, .rst_b, .cmd_start,
		.cmd_drive, .cmd_tape, .cmd_write, .cmd_recal, .cmd_seek,
		.cmd_test_ready, .cmd_xfer, .cmd_init, .init_burst, .init_cyls,
		.cmd_done, .sense_rd, .step_pulse, .track0, .seek_done, .write_prot,
		.index_pulse, .addr_mark, .id_valid, .id_ecc_err, .id_match, .id_cyl,
		.id_head, .tgt_cyl, .tgt_head, .data_valid, .data_err, .err_span,
		.status_q, .msg_q, .msg_valid_q, .reject_q, .abort_q);
	decd_drive_model drv_u (.clk, .track0, .seek_done, .write_prot,
		.index_pulse, .addr_mark, .id_valid, .id_ecc_err, .id_match, .id_cyl,
		.id_head, .data_valid, .data_err, .err_span);
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task chk(input string n, input [7:0] s, input [7:0] e);
		begin
			samples_checked++;
			if (s !== e)
			begin
				n_errors++;
				$display("unexpected %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("errors %0d checks %0d", n_errors, samples_checked);
			if (n_errors == 0 && samples_checked > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// Flags: tape write recal seek test xfer
	task cmd(input [1:0] d, input [5:0] f);
		begin
			{cmd_tape, cmd_write, cmd_recal, cmd_seek, cmd_test_ready, cmd_xfer} = f;
			{cmd_drive, cmd_start} = {d, 1'h1};
			@(posedge clk) #1 cmd_start = 0;
		end
	endtask
	// Bounded wait for the completion byte; flags drop once it is seen
	task fin(input dn, input [7:0] e);
		begin
			cmd_done = dn;
			@(posedge clk) #1 cmd_done = 0;
			for (i = 0; i < 50 && msg_valid_q !== 1'b1; i++)
				@(posedge clk) #1;
			chk("msg_valid", {7'h0, msg_valid_q}, 8'h01);
			chk("msg", msg_q, e);
			{cmd_tape, cmd_write, cmd_recal, cmd_seek, cmd_test_ready,
				cmd_xfer} = 6'h0;
		end
	endtask
	// Step pulses one idle cycle apart
	task steps(input integer n);
		begin
			repeat (n)
			begin
				step_pulse = 1;
				@(posedge clk) #1 step_pulse = 0;
				@(posedge clk) #1;
			end
		end
	endtask
	task sense;
		begin
			sense_rd = 1;
			@(posedge clk) #1 sense_rd = 0;
			chk("status", status_q, 8'h00);
		end
	endtask
	task xf(input [15:0] c, input e, input [7:0] s, input [7:0] x);
		begin
			cmd(0, 6'h01);
			drv_u.mark(0);
			drv_u.idf(0, 1, c);
			drv_u.dat(e, s);
			fin(1, x);
		end
	endtask
	task sn(input e, input [7:0] x);
		begin
			cmd(0, 6'h01);
			drv_u.mark(0);
			drv_u.idf(e, 0, 16'h5);
			drv_u.mark(1);
			@(posedge clk) #1;
			drv_u.mark(1);
			fin(0, x);
		end
	endtask
	task abort21;
		begin
			cmd(0, 6'h01);
			drv_u.mark(0);
			drv_u.idf(0, 1, 16'h5);
			// Marks between data fields keep the mark window quiet
			repeat (21)
			begin
				drv_u.mark(0);
				drv_u.dat(1, 8'h9);
			end
			fin(0, 8'h33);
		end
	endtask
	initial
	begin
		#50000 n_errors++;
		tally_and_finish;
	end
	initial
	begin
		{rst_b, cmd_start, cmd_tape, cmd_write, cmd_recal, cmd_seek} = 6'h0;
		{cmd_test_ready, cmd_xfer, cmd_init, cmd_done, sense_rd} = 5'h0;
		{step_pulse, cmd_drive, tgt_cyl, tgt_head} = {1'h0, 2'h0, 16'h5, 8'h0};
		{init_burst, init_cyls} = {8'h4, 16'h2};
		repeat (10) @(posedge clk);
		#1 rst_b = 1;
		cmd(0, 6'h20);
		fin(0, 8'h0a);
		cmd_init = 1;
		@(posedge clk) #1 cmd_init = 0;
		cmd(1, 6'h01);
		fin(0, 8'h0a);
		sense;
		drv_u.lvl(1, 1);
		cmd(0, 6'h11);
		fin(0, 8'h0b);
		drv_u.lvl(0, 0);
		cmd(0, 6'h04);
		fin(1, 8'h00);
		cmd(0, 6'h02);
		fin(0, 8'h08);
		drv_u.lvl(0, 1);
		xf(16'h5, 0, 8'h0, 8'h00);
		xf(16'h5, 1, 8'h4, 8'h18);
		xf(16'h5, 1, 8'h5, 8'h11);
		xf(16'h6, 0, 8'h0, 8'h15);
		tgt_head = 8'h1;
		xf(16'h5, 0, 8'h0, 8'h15);
		tgt_head = 8'h0;
		sn(0, 8'h14);
		sn(1, 8'h10);
		cmd(0, 6'h01);
		repeat (25) @(posedge clk);
		#1 fin(1, 8'h12);
		cmd(0, 6'h08);
		steps(202);
		fin(0, 8'h06);
		// Track zero seen: the same stepping must end clean
		drv_u.trk(1);
		cmd(0, 6'h08);
		steps(202);
		fin(1, 8'h00);
		drv_u.trk(0);
		abort21;
		sense;
		tally_and_finish;
	end
endmodule // decd_detector_bench
